// ==== rtl/iop_unit.sv ====
// module: gpio ports with counters, timestamps, pin sharing and clock blocks
`timescale 1ns/10ps
// What this block does
// [RULE_01] ports of 1,4,8,16,32 bits; each port all-input or all-output
// [RULE_02] port drives pins or samples them, optionally waiting for a condition
// [RULE_03] a port register access completes in one bus cycle
// [RULE_04] open-collector per port: zero pulls low, one releases pin
// [RULE_05] data passes through a shift stage and a transfer register; input samples go from the pin synchronisers straight into xfer_ff
// [RULE_06] each port has a 16-bit counter timing transfers
// [RULE_07] counter readable any time; timed request waits for counter match
// [RULE_08] counter value saved as timestamp on each transfer
// [RULE_09] enabled link disables ports on shared pins; here link_en disables every port, shared pins or not
// [RULE_10] enabled narrower port takes shared pins from wider ports
// [RULE_11] unshared pins of wider port stay usable
// [RULE_12] port always transfers at full declared width
// [RULE_13] six clock blocks; block 0 is the reference clock
// [RULE_14] clock blocks 1..5 have a programmable divider
// [RULE_15] a clock block may take an external 1-bit clock and divide it
// [RULE_16] input ready strobe qualifies input; output ready strobe accompanies output
// [RULE_17] after reset every port uses clock block 0
// [RULE_18] pin events such as a met condition reach the owning core
// [RULE_19] counter counts active clock-block edges, wraps at 65536
module iop_unit
    import iop_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] pin_in,
    output logic [31:0]      pin_out,
    output logic [31:0]      pin_oe,
    input  wire logic        link_en,
    input  wire logic        ext_clk_pin,
    input  wire logic        input_ready_strobe,
    output logic             output_ready_strobe,
    output logic             irq
);
    // port k: bits [pbase(k)+width-1 : pbase(k)], all starting at pin 0 so narrower overlaps wider
    function automatic logic [31:0] pmask(input int k);
        case (k)
            0:       pmask = 32'h0000_0001;
            1:       pmask = 32'h0000_000f;
            2:       pmask = 32'h0000_00ff;
            3:       pmask = 32'h0000_ffff;
            default: pmask = 32'hffff_ffff;
        endcase
    endfunction

    // ********************************************************
    // input synchronisers
    // ********************************************************
    logic [31:0] pin_s1_ff, pin_s2_ff;
    logic [2:0]  ext_s_ff;
    logic [1:0]  rdy_s_ff;
    always_ff @(posedge aclk) begin
        pin_s1_ff <= pin_in;
        pin_s2_ff <= pin_s1_ff;
        ext_s_ff  <= {ext_s_ff[1:0], ext_clk_pin};
        rdy_s_ff  <= {rdy_s_ff[0], input_ready_strobe};
    end
    wire ext_rise = ext_s_ff[1] & ~ext_s_ff[2];

    // ********************************************************
    // register bus
    // ********************************************************
    logic [31:0] ctrl_ff [NUM_PORTS];
    logic [31:0] dout_ff [NUM_PORTS];
    logic [31:0] cond_ff [NUM_PORTS];
    logic [15:0] time_ff [NUM_PORTS];
    logic [7:0]  cbdiv_ff [NUM_CLKBLK];
    logic [2:0]  sel_ff;
    logic [4:0]  irq_en_ff;
    logic        aw_ff, w_ff;
    logic [7:0]  awa_ff;
    logic [31:0] wd_ff;
    wire         wr_go   = aw_ff & w_ff & ~s_axi_bvalid;
    wire [7:0]   wa      = awa_ff;
    wire         wr_ctrl = wr_go & (wa == A_CTRL);
    wire         wr_dout = wr_go & (wa == A_DOUT);
    wire         wr_clr  = wr_go & (wa == A_IRQ_CLR);
    wire         wr_map  = wa <= A_SEL && wa[1:0] == 2'b00;
    wire [2:0]   ps      = (sel_ff < 3'd5) ? sel_ff : 3'd0;
    assign s_axi_awready = ~aw_ff;
    assign s_axi_wready  = ~w_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff        <= 1'b0;
            w_ff         <= 1'b0;
            awa_ff       <= 8'h00;
            wd_ff        <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff  <= 1'b1;
                awa_ff <= s_axi_awaddr[7:0] | {7'h0, |s_axi_awaddr[31:8]};
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff  <= 1'b1;
                wd_ff <= s_axi_wdata;
            end
            if (wr_go) begin // [RULE_03]
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? RESP_OK : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************************************************
    // clock blocks
    // ********************************************************
    logic [7:0]  cbcnt_ff [NUM_CLKBLK];
    logic [NUM_CLKBLK-1:0] cb_tick;
    genvar g;
    generate
        for (g = 0; g < NUM_CLKBLK; g++) begin : g_cb
            // block 0 ticks every core cycle (REF_DIV is 1); others may use the external pin
            wire src = (g == 0) ? 1'b1 : (cbdiv_ff[g][7] ? ext_rise : 1'b1); // [RULE_15]
            wire [7:0] lim = (g == 0) ? REF_DIV : {1'b0, cbdiv_ff[g][6:0]}; // [RULE_13]
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cbcnt_ff[g] <= 8'h00;
                    cbdiv_ff[g] <= 8'h00;
                end else begin
                    if (src) cbcnt_ff[g] <= (cbcnt_ff[g] + 8'd1 >= lim) ? 8'h00
                                            : cbcnt_ff[g] + 8'd1; // [RULE_14]
                    if (g != 0 && wr_go && wa == A_CBDIV && wd_ff[10:8] == 3'(g))
                        cbdiv_ff[g] <= wd_ff[7:0];
                end
            end
            assign cb_tick[g] = src & (cbcnt_ff[g] + 8'd1 >= lim);
        end
    endgenerate

    // ********************************************************
    // ports
    // ********************************************************
    logic [15:0] cnt_ff   [NUM_PORTS];
    logic [15:0] tstamp_ff[NUM_PORTS];
    logic [31:0] xfer_ff  [NUM_PORTS];
    logic [31:0] shreg_ff [NUM_PORTS];
    iop_xfer_e   st_ff    [NUM_PORTS];
    logic [4:0]  irq_stat_ff;
    logic [NUM_PORTS-1:0] ev;
    logic [NUM_PORTS-1:0] en;
    logic [31:0] owned [NUM_PORTS];
    logic [31:0] taken [NUM_PORTS];
    logic [NUM_PORTS-1:0] ors;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            wire [2:0]  cbs  = ctrl_ff[g][C_CB_LO +: C_CB_W];
            wire        tick = cb_tick[(cbs < 3'd6) ? cbs : 3'd0];
            wire [31:0] m    = pmask(g);
            wire        outp = ctrl_ff[g][C_OUT]; // [RULE_01]
            wire        tmok = !ctrl_ff[g][C_TIMED] || cnt_ff[g] == time_ff[g]; // [RULE_07]
            wire        cdok = !ctrl_ff[g][C_COND_EN] || (pin_s2_ff & m) == (cond_ff[g] & m);
            wire        stok = !ctrl_ff[g][C_STROBE] || outp || rdy_s_ff[1]; // [RULE_16]
            wire        fire = (st_ff[g] == IOP_WAIT) & tick & tmok & cdok & stok;
            assign en[g] = ctrl_ff[g][C_EN] & ~link_en; // [RULE_09]
            if (g == 0) begin : g_own0
                assign taken[g] = 32'h0;
                assign owned[g] = m;
            end else begin : g_own
                // narrower enabled ports take shared pins; the rest stays here
                assign taken[g] = taken[g-1] | (en[g-1] ? pmask(g-1) : 32'h0);
                assign owned[g] = m & ~taken[g]; // [RULE_10] [RULE_11]
            end
            assign ev[g]  = fire & ctrl_ff[g][C_COND_EN]; // [RULE_18]
            assign ors[g] = fire & outp & ctrl_ff[g][C_STROBE];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ctrl_ff[g]   <= CTRL_RST; // [RULE_17]
                    dout_ff[g]   <= 32'h0;
                    cond_ff[g]   <= 32'h0;
                    time_ff[g]   <= 16'h0;
                    cnt_ff[g]    <= 16'h0;
                    tstamp_ff[g] <= 16'h0;
                    xfer_ff[g]   <= 32'h0;
                    shreg_ff[g]  <= 32'h0;
                    st_ff[g]     <= IOP_IDLE;
                end else begin
                    if (tick) cnt_ff[g] <= cnt_ff[g] + 16'd1; // [RULE_06] [RULE_19]
                    if (wr_go && ps == 3'(g)) begin
                        if (wa == A_CTRL) ctrl_ff[g] <= wd_ff;
                        if (wa == A_COND) cond_ff[g] <= wd_ff;
                        if (wa == A_TIME) time_ff[g] <= wd_ff[15:0];
                    end
                    if (wr_dout && ps == 3'(g)) begin
                        xfer_ff[g] <= wd_ff & m; // [RULE_05] [RULE_12]
                        st_ff[g]   <= IOP_WAIT;
                    end else if (wr_ctrl && ps == 3'(g) && wd_ff[C_EN] && !wd_ff[C_OUT]) begin
                        st_ff[g] <= IOP_WAIT;
                    end else if (fire) begin
                        tstamp_ff[g] <= cnt_ff[g]; // [RULE_08]
                        if (outp) shreg_ff[g] <= xfer_ff[g]; // [RULE_05]
                        else xfer_ff[g] <= pin_s2_ff & m; // [RULE_02] [RULE_12]
                        st_ff[g] <= IOP_DONE;
                    end
                end
            end
        end
    endgenerate

    // ********************************************************
    // pin drive
    // ********************************************************
    always_comb begin
        pin_out = 32'h0;
        pin_oe  = 32'h0;
        for (int k = 0; k < NUM_PORTS; k++) begin
            if (en[k] && ctrl_ff[k][C_OUT]) begin
                for (int b = 0; b < 32; b++) begin
                    if (owned[k][b]) begin
                        pin_out[b] = ctrl_ff[k][C_OC] ? 1'b0 : shreg_ff[k][b]; // [RULE_04]
                        pin_oe[b]  = ctrl_ff[k][C_OC] ? ~shreg_ff[k][b] : 1'b1; // [RULE_04]
                    end
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) output_ready_strobe <= 1'b0;
        else output_ready_strobe <= |ors; // [RULE_16]
    end

    // ********************************************************
    // interrupts and read path
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= 5'h0;
            irq_en_ff   <= 5'h0;
            sel_ff      <= 3'h0;
        end else begin
            // set wins over clear
            irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? wd_ff[4:0] : 5'h0)) | ev; // [RULE_18]
            if (wr_go && wa == A_IRQ_EN) irq_en_ff <= wd_ff[4:0];
            if (wr_go && wa == A_SEL) sel_ff <= wd_ff[2:0];
        end
    end
    assign irq = |(irq_stat_ff & irq_en_ff); // [RULE_18]

    wire [7:0] ra = s_axi_araddr[7:0];
    wire       rok = s_axi_araddr[31:8] == 24'h0 && ra <= A_SEL && ra[1:0] == 2'b00;
    wire [31:0] rmux =
        (ra == A_CTRL)     ? ctrl_ff[ps] :
        (ra == A_DOUT)     ? {30'h0, st_ff[ps]} :
        (ra == A_DIN)      ? xfer_ff[ps] :
        (ra == A_COND)     ? cond_ff[ps] :
        (ra == A_TIME)     ? {16'h0, time_ff[ps]} :
        (ra == A_CNT)      ? {16'h0, cnt_ff[ps]} :
        (ra == A_TSTAMP)   ? {16'h0, tstamp_ff[ps]} :
        (ra == A_IRQ_STAT) ? {27'h0, irq_stat_ff} :
        (ra == A_IRQ_EN)   ? {27'h0, irq_en_ff} :
        (ra == A_SEL)      ? {29'h0, sel_ff} : 32'h0;
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1; // [RULE_03] [RULE_07]
            s_axi_rdata  <= rok ? rmux : 32'h0;
            s_axi_rresp  <= rok ? RESP_OK : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    a_link_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
        link_en |-> pin_oe == 32'h0) else $error("pins driven while link enabled");
    a_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
        cb_tick[0] && ctrl_ff[0][C_CB_LO +: C_CB_W] == 3'd0 |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'd1)
        else $error("port counter did not step");
    a_oc_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
        en[0] && ctrl_ff[0][C_OUT] && ctrl_ff[0][C_OC] |-> pin_out[0] == 1'b0)
        else $error("open collector drove high");
    a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
        wr_go |=> s_axi_bvalid) else $error("write answer late");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_18]
        ev[1] && irq_en_ff[1] && !(wr_go && wa == A_IRQ_EN) |=> irq)
        else $error("event lost to irq");
    a_narrow_own: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
        en[0] |-> owned[1][0] == 1'b0) else $error("wider port kept shared pin");
    a_tstamp_cap: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
        st_ff[1] == IOP_WAIT ##1 st_ff[1] == IOP_DONE |-> tstamp_ff[1] == $past(cnt_ff[1]))
        else $error("timestamp not captured");
    a_strobe_wait: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
        st_ff[1] == IOP_WAIT && ctrl_ff[1][C_STROBE] && !ctrl_ff[1][C_OUT] && !rdy_s_ff[1]
        |=> st_ff[1] != IOP_DONE) else $error("input taken without ready strobe");
    a_pin_own: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
        en[0] && ctrl_ff[0][C_OUT] && !ctrl_ff[0][C_OC] |-> pin_out[0] == shreg_ff[0][0])
        else $error("narrow port lost its pin");
    a_wide_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
        en[0] && !en[1] && en[2] && ctrl_ff[2][C_OUT] && !ctrl_ff[2][C_OC]
        |-> pin_out[7:1] == shreg_ff[2][7:1]) else $error("wide port lost unshared pins");
    a_tmr_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
        st_ff[2] == IOP_WAIT && ctrl_ff[2][C_TIMED] && cnt_ff[2] != time_ff[2]
        |=> st_ff[2] != IOP_DONE) else $error("timed transfer before counter match");
    a_cond_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
        st_ff[1] == IOP_WAIT && ctrl_ff[1][C_COND_EN] && pin_s2_ff[3:0] != cond_ff[1][3:0]
        |=> st_ff[1] != IOP_DONE) else $error("sample taken before condition met");
    a_xfer_width: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05] [RULE_12]
        st_ff[1] == IOP_WAIT && !ctrl_ff[1][C_OUT] ##1 st_ff[1] == IOP_DONE
        |-> xfer_ff[1] == ($past(pin_s2_ff) & 32'h0000_000f)) else $error("sample width wrong");
    a_cb_ext: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
        cbdiv_ff[1][7] && !ext_rise |-> !cb_tick[1])
        else $error("external clock block ticked without an edge");
    a_oc_release: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
        en[0] && ctrl_ff[0][C_OUT] && ctrl_ff[0][C_OC] && shreg_ff[0][0] |-> !pin_oe[0])
        else $error("open collector did not release");
    a_ors_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
        ors[2] |=> output_ready_strobe)
        else $error("output ready strobe missing");
    a_oe_input: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
        en[0] && !ctrl_ff[0][C_OUT] |-> !pin_oe[0])
        else $error("input port pin driven");
endmodule

// ==== rtl/iop_pkg.sv ====
// package: register map, field layout and constants of the port/clock-block unit
package iop_pkg;
    localparam int          NUM_PORTS     = 5;
    localparam int          NUM_CLKBLK    = 6;
    localparam int          CNT_W         = 16;
    localparam logic [31:0] PORT_W_0      = 32'd1;
    localparam logic [31:0] PORT_W_1      = 32'd4;
    localparam logic [31:0] PORT_W_2      = 32'd8;
    localparam logic [31:0] PORT_W_3      = 32'd16;
    localparam logic [31:0] PORT_W_4      = 32'd32;
    localparam int          REF_HZ        = 100000000;
    localparam int          SYS_HZ        = 40000000;
    // core clock is below the reference rate, so the reference divider is 1
    localparam logic [7:0]  REF_DIV       = 8'((SYS_HZ + REF_HZ - 1) / REF_HZ);
    // address map
    localparam logic [7:0]  A_CTRL        = 8'h00;
    localparam logic [7:0]  A_DOUT        = 8'h04;
    localparam logic [7:0]  A_DIN         = 8'h08;
    localparam logic [7:0]  A_COND        = 8'h0c;
    localparam logic [7:0]  A_TIME        = 8'h10;
    localparam logic [7:0]  A_CNT         = 8'h14;
    localparam logic [7:0]  A_TSTAMP      = 8'h18;
    localparam logic [7:0]  A_CBDIV       = 8'h1c;
    localparam logic [7:0]  A_IRQ_STAT    = 8'h20;
    localparam logic [7:0]  A_IRQ_EN      = 8'h24;
    localparam logic [7:0]  A_IRQ_CLR     = 8'h28;
    localparam logic [7:0]  A_SEL         = 8'h2c;
    // ctrl fields (per selected port)
    localparam int          C_EN          = 0;
    localparam int          C_OUT         = 1;
    localparam int          C_OC          = 2;
    localparam int          C_COND_EN     = 3;
    localparam int          C_TIMED       = 4;
    localparam int          C_STROBE      = 5;
    localparam int          C_CB_LO       = 8;
    localparam int          C_CB_W        = 3;
    localparam int          C_EXT_CLK     = 11;
    localparam logic [31:0] CTRL_RST      = 32'h0;
    localparam logic [1:0]  RESP_OK       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    typedef enum logic [1:0] {
        IOP_IDLE = 2'b00,
        IOP_WAIT = 2'b01,
        IOP_DONE = 2'b10
    } iop_xfer_e;
endpackage

// ==== tb/iop_pins_model.sv ====
// model of the hardware attached to the port pins
`timescale 1ns/10ps
module iop_pins_model (
    input  wire logic        aclk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    output logic      [31:0] pin_in,
    output logic             ext_clk_pin,
    output logic             input_ready_strobe
);
    logic [31:0] drv_ff = 32'h0;
    logic [31:0] den_ff = 32'h0;
    // pins nobody drives settle on their pull-downs
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & den_ff & drv_ff);
    initial begin
        ext_clk_pin = 1'b0;
        input_ready_strobe = 1'b1;
    end
    task automatic drive(input logic [31:0] m, input logic [31:0] v);
        @(posedge aclk);
        den_ff <= m;
        drv_ff <= v;
    endtask
    task automatic set_ready(input logic v);
        @(posedge aclk);
        input_ready_strobe <= v;
    endtask
    // slow clock, parked low between bursts so no stray edge is counted
    task automatic ext_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge aclk);
            ext_clk_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            ext_clk_pin <= 1'b0;
        end
    endtask
endmodule

// ==== tb/iop_unit_tb.sv ====
// self-checking bench for the port and clock-block unit
`timescale 1ns/10ps
module iop_unit_tb
    import iop_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, link_en;
    logic        ext_clk, in_strobe, out_strobe, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] awaddr, wdata, araddr, rdata, pin_in, pin_out, pin_oe, rd;
    logic [15:0] c0;
    int          bad_count, cmp_count, cyc, t_ar, t_r, t0, strobes;

    iop_unit iop_unit_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .link_en(link_en),
        .ext_clk_pin(ext_clk), .input_ready_strobe(in_strobe),
        .output_ready_strobe(out_strobe), .irq(irq));
    iop_pins_model iop_pins_model_inst (
        .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_clk_pin(ext_clk), .input_ready_strobe(in_strobe));

    // ****************
    // bus tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        t_ar = cyc;
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        t_r = cyc;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_done();
        do rdr(A_DOUT); while (rd[1:0] !== 2'd2);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // strobe is a one-cycle pulse, so cycles high equal pulses
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (out_strobe === 1'b1) begin
            strobes <= strobes + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, link_en, aresetn} = 7'h0;
        {awaddr, wdata, araddr} = 96'h0;
        {bad_count, cmp_count, cyc, strobes} = 128'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk("oe", 32'h0, pin_oe);
        for (int p = 0; p < NUM_PORTS; p++) begin
            wr(A_SEL, 32'(p));
            rdr(A_CTRL);
            chk("ctrl", CTRL_RST, rd);
        end
        rdr(32'h100);
        chk("rresp", 32'(RESP_SLVERR), 32'(resp));
        chk("rdata", 32'h0, rd);
        chk("rlat", 32'd1, 32'(t_r - t_ar));
        wr(32'h100, 32'h1);
        chk("bresp", 32'(RESP_SLVERR), 32'(resp));
        rdr(A_CNT);
        c0 = rd[15:0];
        t0 = t_ar;
        repeat (37) @(posedge aclk);
        rdr(A_CNT);
        chk("cnt", 32'(16'(t_ar - t0)), 32'(rd[15:0] - c0));
        // timed 8-bit output with strobe
        wr(A_SEL, 32'd2);
        wr(A_CTRL, 32'h33);
        rdr(A_CNT);
        c0 = rd[15:0] + 16'd80;
        wr(A_TIME, 32'(c0));
        wr(A_DOUT, 32'ha5);
        rdr(A_DOUT);
        chk("state", 32'd1, rd);
        wait_done();
        rdr(A_TSTAMP);
        chk("tstamp", 32'(c0), rd);
        chk("pins", 32'ha5, pin_out & 32'hff);
        chk("oe", 32'hff, pin_oe);
        chk("strobe", 32'd1, 32'(strobes));
        // 1-bit port over the 8-bit one, then open collector
        wr(A_SEL, 32'd0);
        wr(A_CTRL, 32'h3);
        wr(A_DOUT, 32'h0);
        wait_done();
        chk("pins", 32'ha4, pin_out & 32'hff);
        wr(A_CTRL, 32'h7);
        wr(A_DOUT, 32'h1);
        wait_done();
        chk("oe", 32'hfe, pin_oe);
        wr(A_DOUT, 32'h0);
        wait_done();
        chk("oe", 32'hff, pin_oe);
        chk("pins", 32'ha4, pin_out & 32'hff);
        @(posedge aclk);
        link_en <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("link", 32'h0, pin_oe);
        link_en <= 1'b0;
        // 4-bit input waiting for a pin pattern
        wr(A_CTRL, 32'h0);
        wr(A_SEL, 32'd2);
        wr(A_CTRL, 32'h0);
        iop_pins_model_inst.drive(32'hf, 32'h3);
        wr(A_SEL, 32'd1);
        wr(A_COND, 32'h9);
        wr(A_IRQ_EN, 32'h2);
        wr(A_CTRL, 32'h9);
        repeat (10) @(posedge aclk);
        chk("irq", 32'h0, 32'(irq));
        iop_pins_model_inst.drive(32'hf, 32'h9);
        wait_done();
        iop_pins_model_inst.drive(32'hf, 32'h0);
        rdr(A_DIN);
        chk("din", 32'h9, rd);
        chk("irq", 32'h1, 32'(irq));
        wr(A_IRQ_EN, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        rdr(A_IRQ_STAT);
        chk("stat", 32'h2, rd);
        wr(A_IRQ_CLR, 32'h2);
        rdr(A_IRQ_STAT);
        chk("stat", 32'h0, rd);
        // input held back until the ready strobe comes
        iop_pins_model_inst.set_ready(1'b0);
        wr(A_CTRL, 32'h21);
        repeat (10) @(posedge aclk);
        rdr(A_DOUT);
        chk("held", 32'd1, rd);
        iop_pins_model_inst.set_ready(1'b1);
        wait_done();
        rdr(A_DIN);
        chk("din", 32'h0, rd);
        // clock block 1 from the external pin
        wr(A_CBDIV, 32'h180);
        wr(A_SEL, 32'd3);
        wr(A_CTRL, 32'h101);
        rdr(A_CNT);
        c0 = rd[15:0];
        iop_pins_model_inst.ext_pulses(5);
        repeat (6) @(posedge aclk);
        rdr(A_CNT);
        chk("ext", 32'd5, 32'(rd[15:0] - c0));
        end_sim();
    end
endmodule
